/* core/startup_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef STARTUP_MAP_SVH
`define STARTUP_MAP_SVH
`define OFS_CAUSE      5'h00
`define OFS_BROWNOUT   5'h04
`define OFS_STATUS     5'h08
`define OFS_WATCHDOG   5'h0c
`define OFS_RUN        5'h10
`define CAUSE_RST      8'h0c
`define BIT_OVF        7
`define BIT_UNF        6
`define BIT_PIN        3
`define BIT_INSTR      2
`define BIT_POR        1
`define BIT_BOR        0
`define BIT_TO         4
`define BIT_PD         3
`define BIT_SW_BROWNOUT_ENABLE     7
`define POWERUP_TIMER_MS        64
`define CLK_HZ         25000000
`define POWERUP_TIMER_CYCLES    ((`POWERUP_TIMER_MS * `CLK_HZ) / 1000)
`define OST_CYCLES     1024
`define PC_RESET       15'h0000
`define PC_VECTOR      15'h0004
`define CAUSE_WMASK    8'hcf
`define STATUS_WMASK   8'h07
`define BROWN_WMASK    8'h80
`define WDT_WMASK      8'h3f
`define BROWN_RST      8'h80
`define AXI_OKAY       2'b00
`define AXI_SLVERR     2'b10
`endif

/* core/startup_pkg.sv */
// Types shared by the start-up and reset-cause block
package startup_pkg;
  typedef enum logic [1:0] {
    st_hold = 2'b00,
    st_run  = 2'b01,
    st_sleep = 2'b10
  } seq_state_t;
endpackage

/* core/startup_timer.sv */
// Down counter that expires after a load
`timescale 1ns/1ps
module startup_timer #(
  parameter int unsigned cycles = 16
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic bypass,
  output logic      done
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        running;
  logic        next_running;
  logic        next_done;

  always_comb
  begin
    next_count = count;
    next_running = running;
    next_done = done;
    if (start)
    begin
      next_count = 32'(cycles);
      next_running = !bypass;
      next_done = bypass;
    end
    else if (running)
    begin
      if (count <= 32'h1)
      begin
        next_running = 1'b0;
        next_done = 1'b1;
      end
      else
      begin
        next_count = count - 32'h1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 32'h0;
      running <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end
endmodule

/* core/startup_and_reset_cause.sv */
// Start-up sequencer, reset-cause flags and AXI4-Lite register slave
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "startup_map.svh"
// Summary of operation
// - Run only after timers expire and pin released
// - Timers count regardless of reset pin
// - Expired timers: run at pin release
// - Every reset except watchdog updates cause bits
// - Power-on: PC zero, flags 00 110x, status 11
// - Brown-out: PC zero, flags 00 11u0, status 11
// - Watchdog reset clears timeout; wake clears both
// - Interrupt wake: timeout set, powerdown clear, vector if global irq enabled, else next PC
// - Pin reset running: PC zero, pin flag clear
// - Pin reset sleeping: pin flag, timeout, powerdown
// - Reset instruction clears instruction flag, PC zero
// - Enabled overflow sets overflow flag, PC zero
// - Enabled underflow sets underflow flag, PC zero
// - Firmware writes reach every flag except timeout and powerdown
// - Unimplemented bits read zero
// - Power-up timer delays 64 ms
// - Power-up timer enabled when enable_n low
module startup_and_reset_cause #(
  parameter int unsigned powerup_timer_cycles = `POWERUP_TIMER_CYCLES
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  input  wire logic                      por_event,
  input  wire logic                      brownout_reset,
  input  wire logic                      ext_reset_pin_n,
  input  wire logic                      ext_reset_enable,
  input  wire logic                      powerup_timer_enable_n,
  input  wire logic                      osc_needs_startup,
  input  wire logic                      watchdog_timeout,
  input  wire logic                      irq_wake,
  input  wire logic                      global_irq_enable,
  input  wire logic                      sleep_enter,
  input  wire logic                      reset_instr,
  input  wire logic                      stack_overflow,
  input  wire logic                      stack_underflow,
  input  wire logic                      stack_fault_reset_en,
  input  wire logic                      brownout_ready,
  input  wire logic [14:0]               pc_now,
  output startup_pkg::seq_state_t        seq_state,
  output logic                           core_run,
  output logic                           pc_load,
  output logic [14:0]                    pc_value,
  output logic                           push_return,
  output logic                           sw_brownout_enable,
  output logic [4:0]                     watchdog_prescale,
  output logic                           sw_watchdog_enable,
  input  wire logic [4:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [4:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import startup_pkg::*;

  logic [1:0]  pin_sync;
  logic        pin_low;
  logic        pin_low_d;
  logic        pwr_event;
  logic        powerup_timer_done;
  logic        ost_done;
  logic        cold_start;
  logic        next_cold_start;
  seq_state_t  next_seq_state;
  logic [7:0]  cause;
  logic [7:0]  next_cause;
  logic [1:0]  wake_bits;
  logic [1:0]  next_wake_bits;
  logic [2:0]  alu_flags;
  logic [2:0]  next_alu_flags;
  logic [7:0]  brown_reg;
  logic [7:0]  next_brown_reg;
  logic [7:0]  wdt_reg;
  logic [7:0]  next_wdt_reg;
  logic        next_pc_load;
  logic [14:0] next_pc_value;
  logic        next_push;
  logic        aw_held;
  logic        w_held;
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic        next_w_held;
  logic [4:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        wr_fire;
  logic        pin_reset;
  logic        gates_clear;
  logic [7:0]  status_rd;
  logic [7:0]  rd_byte;
  logic        rd_ok;
  logic [7:0]  wbyte;

  // Pin is asynchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_sync <= 2'b11;
      pin_low_d <= 1'b0;
    end
    else if (ce)
    begin
      pin_sync <= {pin_sync[0], ext_reset_pin_n};
      pin_low_d <= pin_low;
    end
  end

  assign pin_low = ext_reset_enable && !pin_sync[1];
  assign pin_reset = pin_low && !pin_low_d;
  assign pwr_event = por_event || brownout_reset;

  // Timers restart on each power event and ignore the pin
  startup_timer #(.cycles(powerup_timer_cycles)) u_powerup_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (pwr_event),
    .bypass  (powerup_timer_enable_n),
    .done    (powerup_timer_done)
  );

  startup_timer #(.cycles(`OST_CYCLES)) u_ost (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (pwr_event),
    .bypass  (!osc_needs_startup),
    .done    (ost_done)
  );

  // Release needs every gate clear at once
  assign gates_clear = (!cold_start || (powerup_timer_done && ost_done))
                       && !pin_low && !pwr_event;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wbyte = w_data[7:0];

  always_comb
  begin
    next_seq_state = seq_state;
    next_cold_start = cold_start;
    next_cause = cause;
    next_wake_bits = wake_bits;
    next_alu_flags = alu_flags;
    next_brown_reg = brown_reg;
    next_wdt_reg = wdt_reg;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_push = 1'b0;
    // Firmware writes first so hardware events win the same cycle
    if (wr_fire && w_strb[0])
    begin
      case (aw_addr)
        `OFS_CAUSE:
          next_cause = wbyte & `CAUSE_WMASK;
        `OFS_STATUS:
          next_alu_flags = wbyte[2:0];
        `OFS_BROWNOUT:
          next_brown_reg = wbyte & `BROWN_WMASK;
        `OFS_WATCHDOG:
          next_wdt_reg = wbyte & `WDT_WMASK;
        default:
          next_cause = cause;
      endcase
    end
    if (por_event)
    begin
      next_cause = `CAUSE_RST;
      next_wake_bits = 2'b11;
      next_cold_start = 1'b1;
      next_brown_reg = `BROWN_RST;
      next_seq_state = st_hold;
    end
    else if (brownout_reset)
    begin
      next_cause[`BIT_OVF] = 1'b0;
      next_cause[`BIT_UNF] = 1'b0;
      next_cause[`BIT_PIN] = 1'b1;
      next_cause[`BIT_INSTR] = 1'b1;
      next_cause[`BIT_BOR] = 1'b0;
      next_wake_bits = 2'b11;
      next_cold_start = 1'b1;
      next_brown_reg = `BROWN_RST;
      next_seq_state = st_hold;
    end
    else
    begin
      if (pin_reset)
      begin
        next_cause[`BIT_PIN] = 1'b0;
        if (seq_state == st_sleep)
          next_wake_bits = 2'b10;
        next_seq_state = st_hold;
      end
      if (reset_instr && seq_state == st_run)
      begin
        next_cause[`BIT_INSTR] = 1'b0;
        next_seq_state = st_hold;
      end
      if (stack_fault_reset_en && seq_state == st_run)
      begin
        if (stack_overflow)
        begin
          next_cause[`BIT_OVF] = 1'b1;
          next_seq_state = st_hold;
        end
        if (stack_underflow)
        begin
          next_cause[`BIT_UNF] = 1'b1;
          next_seq_state = st_hold;
        end
      end
      case (seq_state)
        st_hold:
        begin
          if (gates_clear)
          begin
            next_seq_state = st_run;
            next_cold_start = 1'b0;
            next_pc_load = 1'b1;
            next_pc_value = `PC_RESET;
          end
        end
        st_run:
        begin
          if (watchdog_timeout)
          begin
            next_wake_bits[1] = 1'b0;
            next_seq_state = st_hold;
          end
          else if (sleep_enter && next_seq_state == st_run)
          begin
            next_wake_bits = 2'b10;
            next_seq_state = st_sleep;
          end
        end
        st_sleep:
        begin
          if (pin_reset)
            next_seq_state = st_hold;
          else if (watchdog_timeout)
          begin
            next_wake_bits = 2'b00;
            next_seq_state = st_run;
            next_pc_load = 1'b1;
            next_pc_value = 15'(pc_now + 15'h1);
          end
          else if (irq_wake)
          begin
            next_wake_bits = 2'b10;
            next_seq_state = st_run;
            next_pc_load = 1'b1;
            next_pc_value = 15'(pc_now + 15'h1);
            next_push = global_irq_enable;
          end
        end
        default:
          next_seq_state = st_hold;
      endcase
    end
    // Interrupt vector follows the next instruction
    if (push_return)
    begin
      next_pc_load = 1'b1;
      next_pc_value = `PC_VECTOR;
    end
    next_brown_reg[0] = brownout_ready;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_state <= st_hold;
      cold_start <= 1'b1;
      cause <= `CAUSE_RST;
      wake_bits <= 2'b11;
      alu_flags <= 3'h0;
      brown_reg <= `BROWN_RST;
      wdt_reg <= 8'h00;
      pc_load <= 1'b0;
      pc_value <= `PC_RESET;
      push_return <= 1'b0;
    end
    else if (ce)
    begin
      seq_state <= next_seq_state;
      cold_start <= next_cold_start;
      cause <= next_cause;
      wake_bits <= next_wake_bits;
      alu_flags <= next_alu_flags;
      brown_reg <= next_brown_reg;
      wdt_reg <= next_wdt_reg;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      push_return <= next_push;
    end
  end

  assign core_run = (seq_state == st_run);
  assign sw_brownout_enable = brown_reg[`BIT_SW_BROWNOUT_ENABLE];
  assign watchdog_prescale = wdt_reg[5:1];
  assign sw_watchdog_enable = wdt_reg[0];
  assign status_rd = {3'h0, wake_bits, alu_flags};

  always_comb
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFS_CAUSE:    rd_byte = cause;
      `OFS_BROWNOUT: rd_byte = brown_reg;
      `OFS_STATUS:   rd_byte = status_rd;
      `OFS_WATCHDOG: rd_byte = wdt_reg;
      `OFS_RUN:      rd_byte = {6'h0, seq_state};
      default:
      begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && !aw_held)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = {s_axi_awaddr[4:2], 2'b00};
    end
    if (s_axi_wvalid && !w_held)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr <= `OFS_RUN) ? `AXI_OKAY : `AXI_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_arvalid && !s_axi_rvalid)
    begin
      next_rvalid = 1'b1;
      next_rdata = {24'h0, rd_byte};
      next_rresp = rd_ok ? `AXI_OKAY : `AXI_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AXI_OKAY;
    end
    else if (ce)
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  property no_run_held_p;
    @(posedge aclk) disable iff (!aresetn)
      (ce && (pin_low || pwr_event)) |=> !core_run;
  endproperty
  run_gate_a: assert property (no_run_held_p)
    else $error("core ran while held");

  por_flags_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      (ce && por_event) |=> (cause[7:1] == 7'h06 && wake_bits == 2'b11))
    else $error("power-on flags wrong");

  bor_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      (ce && brownout_reset && !por_event) |=> !cause[`BIT_BOR])
    else $error("brown-out flag not cleared");

  pin_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      (ce && pin_reset && !pwr_event) |=> !cause[`BIT_PIN] && !core_run)
    else $error("pin reset not recorded");

  instr_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      (ce && reset_instr && core_run && !pwr_event)
        |=> !cause[`BIT_INSTR])
    else $error("instruction flag not cleared");

  sequence ovf_seq;
    ce && stack_overflow && stack_fault_reset_en && core_run && !pwr_event;
  endsequence
  ovf_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      ovf_seq |=> cause[`BIT_OVF] && !core_run)
    else $error("overflow flag not set");

  unf_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      (ce && stack_underflow && stack_fault_reset_en && core_run
        && !pwr_event) |=> cause[`BIT_UNF])
    else $error("underflow flag not set");

  unimpl_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && cause[5:4] == 2'b00)
    else $error("unimplemented bits not zero");

  wdt_reset_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
      (ce && core_run && watchdog_timeout && !pwr_event && !pin_reset)
        |=> !wake_bits[1] && !core_run)
    else $error("watchdog reset wrong");
endmodule

/* dv/reset_pin_model.sv */
// Behavioural external reset pin source with an optional slow release
`timescale 1ns/1ps
module reset_pin_model (
  input  wire logic aclk,
  input  wire logic hold,
  input  wire logic slow,
  output logic      pin_n
);
  logic [1:0] lag;
  initial
  begin
    lag = 2'd0;
    pin_n = 1'b1;
  end
  // Pull-up returns the pin high once released; slow adds a low tail
  always @(posedge aclk)
  begin
    if (hold)
      lag <= slow ? 2'd3 : 2'd0;
    else if (lag != 2'd0)
      lag <= lag - 2'd1;
    pin_n <= !(hold || lag != 2'd0);
  end
endmodule

/* dv/startup_and_reset_cause_test.sv */
// Self-checking bench for the start-up sequencer and reset-cause flags
`timescale 1ns/1ps
`include "startup_map.svh"
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module startup_and_reset_cause_test;
  import startup_pkg::*;
  localparam int unsigned powerup_timer = 20;
  logic        aclk, aresetn, ce, ext_reset_enable, powerup_timer_enable_n;
  logic        osc_needs_startup, global_irq_enable, stack_fault_reset_en;
  logic        brownout_ready, hold_pin, slow_pin, ext_reset_pin_n;
  logic        por_event, brownout_reset, watchdog_timeout, irq_wake;
  logic        sleep_enter, reset_instr, stack_overflow, stack_underflow;
  logic [7:0]  ev, d;
  logic [14:0] pc_now, pc_value, last_pc, exp_pc;
  seq_state_t  seq_state;
  logic        core_run, pc_load, push_return, sw_brownout_enable;
  logic        sw_watchdog_enable;
  logic [4:0]  watchdog_prescale, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          err_count, total_checks, seed, pushes, p0;

  assign {por_event, brownout_reset, watchdog_timeout, irq_wake, sleep_enter,
          reset_instr, stack_overflow, stack_underflow} = ev;

  startup_and_reset_cause #(.powerup_timer_cycles(powerup_timer)) u_dut (
    .aclk, .aresetn, .ce, .por_event, .brownout_reset, .ext_reset_pin_n,
    .ext_reset_enable, .powerup_timer_enable_n, .osc_needs_startup,
    .watchdog_timeout, .irq_wake, .global_irq_enable, .sleep_enter,
    .reset_instr, .stack_overflow, .stack_underflow, .stack_fault_reset_en,
    .brownout_ready, .pc_now, .seq_state, .core_run, .pc_load, .pc_value,
    .push_return, .sw_brownout_enable, .watchdog_prescale,
    .sw_watchdog_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  reset_pin_model u_pin (.aclk, .hold(hold_pin), .slow(slow_pin),
    .pin_n(ext_reset_pin_n));

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Sentinel while any event input or the held pin is active so a missing program counter load shows
  always @(negedge aclk)
  begin
    if (ev != 8'h00 || hold_pin)
      last_pc <= 15'h7fff;
    else if (pc_load)
      last_pc <= pc_value;
    if (push_return)
      pushes <= pushes + 1;
  end

  function automatic logic [7:0] after_evt(logic [7:0] c, int k);
    return k == 2 ? c & 8'hfb : c | (8'h40 << k);
  endfunction

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic fire(input int k);
    ev <= 8'h01 << k;
    @(posedge aclk);
    ev <= 8'h00;
    @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [7:0] v,
                        input logic [3:0] s);
    logic aw_hs, w_hs, b_hs;
    int   n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h5a5a5a, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_hs = 1'b0;
    n = 0;
    while (!b_hs && n < 100)
    begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs)
        s_axi_awvalid <= 1'b0;
      if (w_hs)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    if (!b_hs)
      err_count++;
  endtask

  task automatic axi_rd(input logic [4:0] a);
    logic ar_hs, r_hs;
    int   n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_hs = 1'b0;
    n = 0;
    while (!r_hs && n < 100)
    begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    if (!r_hs)
      err_count++;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    axi_rd(a);
    `CHK(rd_data, {24'h000000, e})
  endtask

  // Only the time-out and power-down bits are compared, upper bits read zero
  task automatic st_chk(input logic [1:0] e);
    axi_rd(`OFS_STATUS);
    `CHK({rd_data[31:5], rd_data[4:3]}, {27'h0, e})
  endtask

  task automatic chk_run(input logic e);
    @(negedge aclk);
    `CHK(core_run, e)
    @(posedge aclk);
  endtask

  task automatic wait_run(input int lim);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (core_run !== 1'b1 && n < lim);
    `CHK(core_run, 1'b1)
    @(posedge aclk);
  endtask

  task automatic go_sleep();
    fire(3);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    `CHK(seq_state, st_sleep)
    @(posedge aclk);
  endtask

  task automatic pin_pulse();
    hold_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    hold_pin <= 1'b0;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    wrap_up();
  end

  initial
  begin
    {aresetn, ev, pc_now, hold_pin, slow_pin, osc_needs_startup} = '0;
    {global_irq_enable, powerup_timer_enable_n, s_axi_awaddr} = '0;
    {s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ce, ext_reset_enable, stack_fault_reset_en, brownout_ready} = '1;
    {err_count, total_checks, pushes} = '0;
    seed = 50;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`OFS_CAUSE, 8'h0c);
    st_chk(2'b11);
    rd_chk(`OFS_BROWNOUT, 8'h81);
    chk_run(1'b0);
    hold_pin <= 1'b1;
    fire(7);
    repeat (powerup_timer + 10) @(posedge aclk);
    chk_run(1'b0);
    hold_pin <= 1'b0;
    wait_run(8);
    $display("test pin held through power-on done");
    axi_wr(`OFS_CAUSE, 8'h0f, 4'h1);
    fire(7);
    repeat (powerup_timer - 6) @(posedge aclk);
    chk_run(1'b0);
    wait_run(20);
    `CHK(last_pc, `PC_RESET)
    rd_chk(`OFS_CAUSE, 8'h0c);
    st_chk(2'b11);
    powerup_timer_enable_n <= 1'b1;
    fire(7);
    wait_run(6);
    osc_needs_startup <= 1'b1;
    fire(7);
    repeat (900) @(posedge aclk);
    chk_run(1'b0);
    wait_run(300);
    osc_needs_startup <= 1'b0;
    $display("test start-up timers done");
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($random(seed));
      axi_wr(`OFS_CAUSE, d, 4'hf);
      rd_chk(`OFS_CAUSE, d & 8'hcf);
      axi_wr(`OFS_WATCHDOG, d, 4'h1);
      rd_chk(`OFS_WATCHDOG, d & 8'h3f);
      `CHK({watchdog_prescale, sw_watchdog_enable}, d[5:0])
      axi_wr(`OFS_BROWNOUT, d, 4'h1);
      rd_chk(`OFS_BROWNOUT, {d[7], 7'h01});
      `CHK(sw_brownout_enable, d[7])
    end
    axi_wr(`OFS_CAUSE, ~d, 4'he);
    rd_chk(`OFS_CAUSE, d & 8'hcf);
    axi_rd(5'h14);
    `CHK({resp, rd_data}, {`AXI_SLVERR, 32'h0})
    axi_wr(5'h18, 8'hff, 4'h1);
    `CHK(resp, `AXI_SLVERR)
    $display("test firmware access done");
    for (int k = 0; k < 3; k++)
    begin
      axi_wr(`OFS_CAUSE, 8'h0f, 4'h1);
      fire(k);
      wait_run(40);
      `CHK(last_pc, `PC_RESET)
      rd_chk(`OFS_CAUSE, after_evt(8'h0f, k));
    end
    stack_fault_reset_en <= 1'b0;
    axi_wr(`OFS_CAUSE, 8'h0f, 4'h1);
    fire(1);
    chk_run(1'b1);
    rd_chk(`OFS_CAUSE, 8'h0f);
    ext_reset_enable <= 1'b0;
    pin_pulse();
    chk_run(1'b1);
    repeat (4) @(posedge aclk);
    ext_reset_enable <= 1'b1;
    @(posedge aclk);
    $display("test run-time faults done");
    slow_pin <= 1'b1;
    pin_pulse();
    wait_run(30);
    `CHK(last_pc, `PC_RESET)
    rd_chk(`OFS_CAUSE, 8'h07);
    st_chk(2'b11);
    fire(5);
    wait_run(30);
    `CHK(last_pc, `PC_RESET)
    st_chk(2'b01);
    $display("test pin and watchdog reset done");
    for (int g = 0; g < 2; g++)
    begin
      global_irq_enable <= g[0];
      pc_now <= 15'($random(seed)) & 15'h3fff;
      p0 = pushes;
      go_sleep();
      exp_pc = g ? `PC_VECTOR : pc_now + 15'd1;
      fire(4);
      wait_run(30);
      repeat (4) @(posedge aclk);
      `CHK(last_pc, exp_pc)
      `CHK(pushes, p0 + g)
      st_chk(2'b10);
    end
    go_sleep();
    exp_pc = pc_now + 15'd1;
    fire(5);
    wait_run(30);
    `CHK(last_pc, exp_pc)
    st_chk(2'b00);
    axi_wr(`OFS_CAUSE, 8'h0f, 4'h1);
    go_sleep();
    pin_pulse();
    wait_run(30);
    `CHK(last_pc, `PC_RESET)
    rd_chk(`OFS_CAUSE, 8'h07);
    st_chk(2'b10);
    $display("test sleep wake-ups done");
    for (int b = 0; b < 2; b++)
    begin
      d = b ? 8'h41 : 8'h03;
      axi_wr(`OFS_CAUSE, d, 4'h1);
      fire(6);
      wait_run(40);
      `CHK(last_pc, `PC_RESET)
      rd_chk(`OFS_CAUSE, {6'h03, d[1], 1'b0});
      st_chk(2'b11);
    end
    $display("test brown-out done");
    ce <= 1'b0;
    fire(5);
    ce <= 1'b1;
    chk_run(1'b1);
    st_chk(2'b11);
    $display("test clock enable freeze done");
    wrap_up();
  end
endmodule
